// ---- pkg/pimen_pkg.sv ----
// package for the pin interrupt mode and enable block
// assumes apb with 32-bit data, byte addresses of aligned words
package pimen_pkg;
    localparam int unsigned PIMEN_CHANNELS = 8;
    localparam logic [11:0] PIMEN_OFS_MODE = 12'h000;
    localparam logic [11:0] PIMEN_OFS_ENABLE = 12'h004;
    localparam logic [11:0] PIMEN_OFS_ENABLE_SET = 12'h008;
    localparam logic [11:0] PIMEN_OFS_ENABLE_CLEAR = 12'h00c;
    localparam logic [11:0] PIMEN_OFS_FALL_POL = 12'h010;
    localparam logic [11:0] PIMEN_OFS_RISE_DET = 12'h014;
    localparam logic [11:0] PIMEN_OFS_FALL_DET = 12'h018;
    localparam logic [11:0] PIMEN_OFS_IRQ_STATUS = 12'h01c;
    localparam logic [11:0] PIMEN_OFS_IRQ_MASK = 12'h020;
    localparam logic [7:0] PIMEN_RST_MODE = 8'h00;
    localparam logic [7:0] PIMEN_RST_ENABLE = 8'h00;
    localparam logic [7:0] PIMEN_RST_FALL_POL = 8'h00;
    localparam logic [7:0] PIMEN_RST_DET = 8'h00;
    localparam logic [7:0] PIMEN_RST_MASK = 8'h00;
    localparam logic [1:0] PIMEN_SYNC_STAGES = 2'd2;

    // apb request seen by the slave
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } pimen_apb_req_t;

    // per-channel configuration bundle
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] enable;
        logic [7:0] fall_pol;
    } pimen_cfg_t;
endpackage

// ---- verilog/pimen_chan.sv ----
// one pin interrupt channel: edge record and request forming
// assumes the pin is already synchronised to core_clk
module pimen_chan (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pin,
    input wire logic mode,
    input wire logic enable,
    input wire logic fall_pol,
    input wire logic rise_clr,
    input wire logic fall_clr,
    output logic rise_det,
    output logic fall_det,
    output logic req
);
    logic pin_d;

    // previous pin sample for edge detection
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_d <= 1'b0;
        end else begin
            pin_d <= pin;
        end
    end

    // edges recorded regardless of enables; new edge beats clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_det <= 1'b0;
            fall_det <= 1'b0;
        end else begin
            rise_det <= (pin & ~pin_d) | (rise_det & ~rise_clr);
            fall_det <= (~pin & pin_d) | (fall_det & ~fall_clr);
        end
    end

    // edge mode: enabled records; level mode: pin against active level
    always_comb begin
        if (mode) begin
            req = enable & (pin == fall_pol);
        end else begin
            req = (enable & rise_det) | (fall_pol & fall_det);
        end
    end
endmodule

// ---- verilog/pimen_top.sv ----
// top of the pin interrupt mode and enable block, apb slave
// assumes pins arrive asynchronously from the pin selector
module pimen_top (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pin_selector_n,
    output logic [7:0] chan_irq,
    output logic irq
);
    // ****************************************
    // reset and pin synchronisation
    // ****************************************
    logic [1:0] rst_sync;
    logic rst_n;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;

    // two-flop reset release
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // two-flop pin synchroniser
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end else begin
            pin_meta <= pin_selector_n;
            pin_sync <= pin_meta;
        end
    end

    // ****************************************
    // apb decode
    // ****************************************
    pimen_pkg::pimen_apb_req_t req;
    pimen_pkg::pimen_cfg_t cfg;
    // one register per configuration field, so that each has a single driver
    logic [7:0] sensitivity_bits;
    logic [7:0] rise_level_enable_bits;
    logic [7:0] fall_pol_bits;
    logic access;
    logic wr;
    logic [7:0] wbits;
    logic hit;
    logic [7:0] rise_det;
    logic [7:0] fall_det;
    logic [7:0] chan_req;
    logic [7:0] rise_clr;
    logic [7:0] fall_clr;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [7:0] req_d;
    logic [31:0] next_prdata;
    logic next_slverr;

    // request bundle and access strobe
    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
    assign access = req.sel & req.enable & pready;
    assign wr = access & req.write;
    assign wbits = req.wdata[7:0]; // upper bits reserved

    // address hit check
    always_comb begin
        case (req.addr)
            pimen_pkg::PIMEN_OFS_MODE,
            pimen_pkg::PIMEN_OFS_ENABLE,
            pimen_pkg::PIMEN_OFS_ENABLE_SET,
            pimen_pkg::PIMEN_OFS_ENABLE_CLEAR,
            pimen_pkg::PIMEN_OFS_FALL_POL,
            pimen_pkg::PIMEN_OFS_RISE_DET,
            pimen_pkg::PIMEN_OFS_FALL_DET,
            pimen_pkg::PIMEN_OFS_IRQ_STATUS,
            pimen_pkg::PIMEN_OFS_IRQ_MASK: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // ****************************************
    // configuration registers
    // ****************************************
    // mode register
    // a change of mode takes effect as soon as it is written; no record is cleared by it,
    // so software should clear stale edge records after switching to edge mode
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sensitivity_bits <= pimen_pkg::PIMEN_RST_MODE;
        end else if (wr && req.addr == pimen_pkg::PIMEN_OFS_MODE) begin
            sensitivity_bits <= wbits;
        end
    end

    // enable register with set and clear aliases
    // the aliases let software change single channels without a read-modify-write,
    // which would race against another agent touching other channels
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_level_enable_bits <= pimen_pkg::PIMEN_RST_ENABLE;
        end else if (wr) begin
            case (req.addr)
                pimen_pkg::PIMEN_OFS_ENABLE: begin
                    rise_level_enable_bits <= wbits;
                end
                pimen_pkg::PIMEN_OFS_ENABLE_SET: begin
                    rise_level_enable_bits <= rise_level_enable_bits | wbits;
                end
                pimen_pkg::PIMEN_OFS_ENABLE_CLEAR: begin
                    rise_level_enable_bits <= rise_level_enable_bits & ~wbits;
                end
                default: begin
                    rise_level_enable_bits <= rise_level_enable_bits;
                end
            endcase
        end
    end

    // falling edge enable or active level
    // one bit serves both meanings; the mode bit decides which one applies
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fall_pol_bits <= pimen_pkg::PIMEN_RST_FALL_POL;
        end else if (wr && req.addr == pimen_pkg::PIMEN_OFS_FALL_POL) begin
            fall_pol_bits <= wbits;
        end
    end

    // configuration bundle handed to the channels
    assign cfg = '{mode: sensitivity_bits, enable: rise_level_enable_bits,
        fall_pol: fall_pol_bits};

    // write-one-to-clear strobes for edge records
    assign rise_clr = (wr && req.addr == pimen_pkg::PIMEN_OFS_RISE_DET) ? wbits : 8'h00;
    assign fall_clr = (wr && req.addr == pimen_pkg::PIMEN_OFS_FALL_DET) ? wbits : 8'h00;

    // ****************************************
    // channels
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < pimen_pkg::PIMEN_CHANNELS; gi++) begin : g_chan
            pimen_chan u_chan (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .pin(pin_sync[gi]),
                .mode(cfg.mode[gi]),
                .enable(cfg.enable[gi]),
                .fall_pol(cfg.fall_pol[gi]),
                .rise_clr(rise_clr[gi]),
                .fall_clr(fall_clr[gi]),
                .rise_det(rise_det[gi]),
                .fall_det(fall_det[gi]),
                .req(chan_req[gi])
            );
        end
    endgenerate

    // registered per-channel request outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_irq <= 8'h00;
            req_d <= 8'h00;
        end else begin
            chan_irq <= chan_req;
            req_d <= chan_req;
        end
    end

    // ****************************************
    // interrupt status and mask
    // ****************************************
    // sticky status on request rise; set beats write-one clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= pimen_pkg::PIMEN_RST_DET;
        end else begin
            irq_status <= (chan_req & ~req_d) | (irq_status &
                ~((wr && req.addr == pimen_pkg::PIMEN_OFS_IRQ_STATUS) ? wbits : 8'h00));
        end
    end

    // mask register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= pimen_pkg::PIMEN_RST_MASK;
        end else if (wr && req.addr == pimen_pkg::PIMEN_OFS_IRQ_MASK) begin
            irq_mask <= wbits;
        end
    end

    // combined level interrupt
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // ****************************************
    // apb answer
    // ****************************************
    // read mux; write-only aliases read zero
    always_comb begin
        next_prdata = 32'h0000_0000;
        case (req.addr)
            pimen_pkg::PIMEN_OFS_MODE: next_prdata[7:0] = cfg.mode;
            pimen_pkg::PIMEN_OFS_ENABLE: next_prdata[7:0] = cfg.enable;
            pimen_pkg::PIMEN_OFS_FALL_POL: next_prdata[7:0] = cfg.fall_pol;
            pimen_pkg::PIMEN_OFS_RISE_DET: next_prdata[7:0] = rise_det;
            pimen_pkg::PIMEN_OFS_FALL_DET: next_prdata[7:0] = fall_det;
            pimen_pkg::PIMEN_OFS_IRQ_STATUS: next_prdata[7:0] = irq_status;
            pimen_pkg::PIMEN_OFS_IRQ_MASK: next_prdata[7:0] = irq_mask;
            default: next_prdata = 32'h0000_0000;
        endcase
        next_slverr = ~hit;
    end

    // one wait state: pready high in the second access cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= req.sel & req.enable & ~pready;
            prdata <= (req.sel & req.enable & ~pready & ~req.write) ? next_prdata : 32'h0000_0000;
            pslverr <= req.sel & req.enable & ~pready & next_slverr;
        end
    end
endmodule

// ---- tb/pimen_pin_model.sv ----
// model of the external pin selector that feeds the channel pins
// assumes the bench asks for pin levels on pin_req
module pimen_pin_model (
    input wire logic core_clk,
    input wire logic [7:0] pin_req,
    output logic [7:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pins = 8'h00;
    // routed pins follow the request one edge later, like a mux output
    always @(posedge core_clk) begin
        pins <= pin_req;
    end
endmodule

// ---- tb/pimen_sva.sv ----
// checker for the apb side and request outputs of pimen_top
// assumes it is bound to pimen_top and sees only its ports
module pimen_sva (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] chan_irq,
    input wire logic irq
);
    logic [7:0] en_q;
    logic [7:0] fp_q;
    logic [7:0] mk_q;
    // shadow of enable, polarity and mask from taken writes
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            en_q <= 8'h00;
            fp_q <= 8'h00;
            mk_q <= 8'h00;
        end else if (psel && penable && pready && pwrite) begin
            case (paddr)
                pimen_pkg::PIMEN_OFS_ENABLE: en_q <= pwdata[7:0];
                pimen_pkg::PIMEN_OFS_ENABLE_SET: en_q <= en_q | pwdata[7:0];
                pimen_pkg::PIMEN_OFS_ENABLE_CLEAR: en_q <= en_q & ~pwdata[7:0];
                pimen_pkg::PIMEN_OFS_FALL_POL: fp_q <= pwdata[7:0];
                pimen_pkg::PIMEN_OFS_IRQ_MASK: mk_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    property p_answer; psel && penable && !pready |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_map;
        pready |-> pslverr == (paddr[1:0] != 2'b00 || paddr > 12'h020);
    endproperty
    a_map: assert property (p_map) else $error("bad error flag");
    property p_wo; pready && !pwrite && paddr inside {12'h008, 12'h00c} |-> prdata == 32'h0; endproperty
    a_wo: assert property (p_wo) else $error("alias read not zero");
    property p_rsv; !pready || pwrite || pslverr |-> prdata == 32'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("stray read data");
    property p_en; pready && !pwrite && paddr == 12'h004 |-> prdata == {24'h0, en_q}; endproperty
    a_en: assert property (p_en) else $error("enable mismatch");
    property p_noreq; (en_q == 8'h00 && fp_q == 8'h00) [*3] |-> chan_irq == 8'h00; endproperty
    a_noreq: assert property (p_noreq) else $error("request while disabled");
    property p_noirq; (mk_q == 8'h00) [*3] |-> !irq; endproperty
    a_noirq: assert property (p_noirq) else $error("irq while masked");
    c_err: cover property (pready && pslverr);
    c_set: cover property (pready && pwrite && paddr == 12'h008);
    c_irq: cover property ($rose(irq));
endmodule
bind pimen_top pimen_sva i_pimen_sva (.core_clk(core_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_irq(chan_irq), .irq(irq));

// ---- tb/tb_pimen_top.sv ----
// self-checking bench for pimen_top with an integer model
// assumes pimen_pin_model and pimen_sva are compiled first
module tb_pimen_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, err;
    logic [11:0] paddr = 12'h000;
    logic [11:0] regs [5] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [7:0] pin_req = 8'h00, pins, chan_irq;
    int num_errors = 0, tests_run = 0, seed = 32'hc990, i, v, m_mode = 0, m_en = 0, m_fp = 0;
    always #20 core_clk = ~core_clk;
    pimen_top i_pimen_top (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_selector_n(pins), .chan_irq(chan_irq), .irq(irq));
    pimen_pin_model i_pimen_pin_model (.core_clk(core_clk), .pin_req(pin_req), .pins(pins));
    // ****
    // tasks
    // ****
    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            num_errors++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        check(err, a > 12'h020);
        if (a == 12'h000) m_mode = d[7:0];
        if (a == 12'h004) m_en = d[7:0];
        if (a == 12'h008) m_en |= d[7:0];
        if (a == 12'h00c) m_en &= ~d[7:0];
        if (a == 12'h010) m_fp = d[7:0];
    endtask
    task automatic rdc(input logic [11:0] a, input int e);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, e);
        check(err, a > 12'h020);
    endtask
    function automatic int mexp(input logic [11:0] a);
        return (a == 12'h000) ? m_mode : (a == 12'h004) ? m_en : (a == 12'h010) ? m_fp : 0;
    endfunction
    // ****
    // main sequence
    // ****
    initial begin
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        // reset values, then random writes through all five places
        for (i = 0; i < 25; i++) begin
            if (i > 4) wr(regs[i % 5], $random(seed));
            rdc(regs[i % 5], mexp(regs[i % 5]));
            rdc(12'h004, m_en);
        end
        wr(12'h040, 32'hffff_ffff);
        rdc(12'h040, 0);
        // level mode: request is the pin against the chosen level
        wr(12'h000, 32'h0000_00ff);
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            pin_req <= v[7:0];
            wr(12'h004, v[15:8]);
            wr(12'h010, v[23:16]);
            repeat (6) @(posedge core_clk);
            check(chan_irq, m_en & ~(v[7:0] ^ m_fp) & 8'hff);
        end
        // edge mode: rising edges recorded on every pin
        wr(12'h000, 0);
        wr(12'h010, 0);
        pin_req <= 8'h00;
        repeat (6) @(posedge core_clk);
        wr(12'h014, 32'h0000_00ff);
        wr(12'h018, 32'h0000_00ff);
        v = $random(seed);
        wr(12'h004, v[7:0] | 8'h01);
        wr(12'h020, 32'h0000_00ff);
        wr(12'h01c, 32'h0000_00ff);
        pin_req <= 8'hff;
        repeat (6) @(posedge core_clk);
        check(chan_irq, m_en);
        rdc(12'h014, 8'hff);
        rdc(12'h01c, m_en);
        check(irq, 1'b1);
        wr(12'h020, 0);
        repeat (4) @(posedge core_clk);
        check(irq, 1'b0);
        wr(12'h014, 32'h0000_00ff);
        wr(12'h00c, 32'h0000_00ff);
        repeat (4) @(posedge core_clk);
        check(chan_irq, 8'h00);
        rdc(12'h014, 0);
        // edge mode: falling edges raise requests through the polarity bits
        wr(12'h010, 32'h0000_00ff);
        pin_req <= 8'h00;
        repeat (6) @(posedge core_clk);
        check(chan_irq, 8'hff);
        conclude();
    end
endmodule
